// [rtl/bridge_device.sv]
// Bridge device end: configuration bank, synthesizer, lane output formatting
//
// Summary of operation
// RULE1: Enable low: reset, ignore inputs, float outputs
// RULE2: Controller holds enable low ten ms
// RULE3: Transmitter keeps lanes LP11 during reset
// RULE4: Controller waits one ms after enable
// RULE5: Configure first, then start video
// RULE6: Synth enable, poll lock, then restart
// RULE7: Source select bit picks pixel clock
// RULE8: Input clock continuous when used as source
// RULE9: External reference multiplied by factor field
// RULE10: Reference frequency within 25 to 154 MHz
// RULE11: Input clock divided by divider field
// RULE12: Ranges programmed before synth enable
// RULE13: Idle video sends zero pixels, sync kept
// RULE14: Layout two puts colour MSBs on fourth lane
// RULE15: Layout one puts colour LSBs on fourth lane
// RULE16: Narrow mode drops LSBs, fourth lane off
// RULE17: Lanes start only after lock, others low
module bridge_device (
  input wire logic pclk,
  input wire logic presetn,
  bridge_if.dev link,
  input wire logic ref_clk_on,
  output logic [bridge_pkg::LANES-1:0][6:0] lane_bits,
  output logic [bridge_pkg::LANES-1:0] lane_oe,
  output logic [6:0] clk_bits,
  output logic clk_oe,
  output logic synth_locked
);
  import bridge_pkg::*;

  logic [7:0] clksrc_q, clkdiv_q, synth_q, band_q, format_q;
  logic ack_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_d;
  logic [6:0] lock_cnt_q;
  logic lock_q;
  logic live_q;
  logic [7:0] per_cnt_q;
  logic [7:0] period;
  logic strobe;
  logic src_active;
  logic take;
  logic [23:0] pix_q;
  logic hs_q, vs_q, de_q;
  logic [3:0][6:0] mapped;
  logic fourth_en;
  logic [3:0][6:0] lane_q;
  logic [3:0] oe_q;
  logic [6:0] clk_q;
  logic clk_oe_q;

  function automatic logic [7:0] ref_period(input logic [1:0] mult);
    case (mult)
      2'd0: ref_period = REF_PER_X1;
      2'd1: ref_period = REF_PER_X2;
      2'd2: ref_period = REF_PER_X3;
      default: ref_period = REF_PER_X4;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration port
  assign take = link.en && link.cfg_req && !ack_q; // RULE1

  always_comb begin
    case (link.cfg_addr)
      CFG_CLKSRC: begin
        rd_d = clksrc_q;
        rd_d[LOCK_BIT] = lock_q;
      end
      CFG_CLKDIV: rd_d = clkdiv_q;
      CFG_SYNTH: rd_d = synth_q;
      CFG_BAND: rd_d = band_q;
      CFG_FORMAT: rd_d = format_q;
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
    end else if (!link.en) begin
      ack_q <= 1'b0; // RULE1
      rdata_q <= 8'h00;
    end else begin
      ack_q <= take;
      if (take && !link.cfg_wr) begin
        rdata_q <= rd_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clksrc_q <= CFG_RST;
      clkdiv_q <= CFG_RST;
      synth_q <= CFG_RST;
      band_q <= CFG_RST;
      format_q <= CFG_RST;
    end else if (!link.en) begin
      clksrc_q <= CFG_RST; // RULE1
      clkdiv_q <= CFG_RST;
      synth_q <= CFG_RST;
      band_q <= CFG_RST;
      format_q <= CFG_RST;
    end else if (take && link.cfg_wr) begin
      case (link.cfg_addr)
        CFG_CLKSRC: clksrc_q <= {1'b0, link.cfg_wdata[6:0]}; // RULE7
        CFG_CLKDIV: clkdiv_q <= link.cfg_wdata;
        CFG_SYNTH: synth_q <= link.cfg_wdata;
        CFG_BAND: band_q <= link.cfg_wdata;
        CFG_FORMAT: format_q <= link.cfg_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synthesizer lock and logic restart
  assign src_active = clksrc_q[SRC_BIT] ? ref_clk_on : link.hs_clk_cont; // RULE7

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt_q <= 7'h00;
      lock_q <= 1'b0;
    end else if (!link.en || !synth_q[SYNTH_BIT] || !src_active) begin
      lock_cnt_q <= 7'h00;
      lock_q <= 1'b0;
    end else if (lock_cnt_q == 7'(LOCK_CYC - 1)) begin
      lock_q <= 1'b1;
    end else begin
      lock_cnt_q <= lock_cnt_q + 7'h01;
    end
  end

  // No lane data or clock pattern leaves the device until a restart after lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_q <= 1'b0;
    end else if (!link.en || !lock_q) begin
      live_q <= 1'b0; // RULE17
    end else if (take && link.cfg_wr && link.cfg_addr == CFG_RESTART &&
                 link.cfg_wdata[RESTART_BIT]) begin
      live_q <= 1'b1; // RULE5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel clock generation
  always_comb begin
    if (clksrc_q[SRC_BIT]) begin
      period = ref_period(clkdiv_q[MULT_LO +: 2]); // RULE9
    end else begin
      period = {3'b000, clkdiv_q[DIV_LO +: 5]} + 8'h01; // RULE11
    end
  end

  assign strobe = per_cnt_q >= period - 8'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_q <= 8'h00;
    end else if (!lock_q || strobe) begin
      per_cnt_q <= 8'h00;
    end else begin
      per_cnt_q <= per_cnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Video capture and lane formatting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_q <= 24'h000000;
      hs_q <= 1'b0;
      vs_q <= 1'b0;
      de_q <= 1'b0;
    end else if (!link.en || link.lp11) begin
      pix_q <= 24'h000000; // RULE1
      hs_q <= 1'b0;
      vs_q <= 1'b0;
      de_q <= 1'b0;
    end else begin
      hs_q <= link.vid_hs; // RULE13
      vs_q <= link.vid_vs;
      de_q <= link.vid_valid && link.vid_de;
      pix_q <= (link.vid_valid && link.vid_de) ? link.vid_rgb : 24'h000000; // RULE13
    end
  end

  lane_mapper u_lane_mapper (
    .rgb(pix_q),
    .hs(hs_q),
    .vs(vs_q),
    .de(de_q),
    .layout_sel(format_q[LAYOUT_BIT]),
    .wide_mode(format_q[WIDE_BIT]),
    .lane(mapped),
    .fourth_en(fourth_en)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_q <= '0;
      clk_q <= 7'h00;
    end else if (!live_q) begin
      lane_q <= '0; // RULE17
      clk_q <= 7'h00;
    end else if (strobe) begin
      lane_q <= mapped; // RULE14
      clk_q <= CLK_PATTERN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_q <= 4'h0;
      clk_oe_q <= 1'b0;
    end else begin
      oe_q <= {live_q && fourth_en, {3{live_q}}}; // RULE17
      clk_oe_q <= live_q; // RULE1
    end
  end

  assign lane_bits = lane_q;
  assign lane_oe = oe_q;
  assign clk_bits = clk_q;
  assign clk_oe = clk_oe_q;
  assign synth_locked = lock_q;
  assign link.cfg_ack = ack_q;
  assign link.cfg_rdata = rdata_q;
endmodule

// [rtl/bridge_host.sv]
// Controller end: APB registers and power-up sequence for the bridge
//
// Implementation choices: the placing of the registers and the APB register port.
module bridge_host #(
  parameter int RESET_CYCLES = bridge_pkg::RESET_CYC,
  parameter int SETTLE_CYCLES = bridge_pkg::SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic src_valid,
  input wire logic [23:0] src_rgb,
  input wire logic src_hs,
  input wire logic src_vs,
  input wire logic src_de,
  bridge_if.host link
);
  import bridge_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_RESET = 4'b0001, S_SETTLE = 4'b0010, S_CFG = 4'b0011,
    S_VIDEO = 4'b0100, S_SYNTH = 4'b0101, S_POLL = 4'b0110, S_RESTART = 4'b0111,
    S_RUN = 4'b1000, S_ERR = 4'b1001
  } state_t;

  state_t st_q;
  logic [31:0] cnt_q;
  logic [1:0] idx_q;
  logic [31:0] cfg0_q, cfg1_q;
  logic [1:0] ist_q, imask_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, irq_q;
  logic acc, wr, start, stop, ev_done, ev_err, ref_ok, mapped;
  logic req_q, wr_q;
  logic [7:0] addr_q, wdata_q;
  logic en_q, video_q;

  function automatic logic [15:0] init_entry(input logic [1:0] i, input logic [31:0] c);
    case (i)
      2'd0: init_entry = {CFG_CLKSRC, c[7:0]};
      2'd1: init_entry = {CFG_CLKDIV, c[15:8]};
      2'd2: init_entry = {CFG_BAND, c[23:16]};
      default: init_entry = {CFG_FORMAT, c[31:24]};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  assign acc = psel && penable && pready_q;
  assign wr = acc && pwrite;
  assign start = wr && paddr == A_CTRL && pwdata[0];
  assign stop = wr && paddr == A_CTRL && pwdata[1];
  assign mapped = paddr == A_CTRL || paddr == A_CFG0 || paddr == A_CFG1 ||
                  paddr == A_STATUS || paddr == A_INT_STAT || paddr == A_INT_MASK;
  assign ref_ok = !cfg0_q[SRC_BIT] ||
                  (cfg1_q[7:0] >= 8'(REF_MIN_MHZ) && cfg1_q[7:0] <= 8'(REF_MAX_MHZ)); // RULE10

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          A_CFG0: prdata_q <= cfg0_q;
          A_CFG1: prdata_q <= cfg1_q;
          A_STATUS: prdata_q <= {27'h0, st_q == S_RUN, st_q};
          A_INT_STAT: prdata_q <= {30'h0, ist_q};
          A_INT_MASK: prdata_q <= {30'h0, imask_q};
          default: prdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg0_q <= 32'h00000000;
      cfg1_q <= 32'h00000000;
      imask_q <= 2'b00;
    end else if (wr) begin
      if (paddr == A_CFG0) cfg0_q <= pwdata;
      if (paddr == A_CFG1) cfg1_q <= pwdata;
      if (paddr == A_INT_MASK) imask_q <= pwdata[1:0];
    end
  end

  // Read clears; a new event in the same cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= 2'b00;
      irq_q <= 1'b0;
    end else begin
      ist_q <= (acc && !pwrite && paddr == A_INT_STAT ? 2'b00 : ist_q) | {ev_err, ev_done};
      irq_q <= |(ist_q & imask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-up sequencer
  assign ev_done = st_q == S_RESTART && link.cfg_ack;
  assign ev_err = (start && !ref_ok) || (st_q == S_POLL && link.cfg_ack &&
                  !link.cfg_rdata[LOCK_BIT] && cnt_q == 32'(POLL_LIMIT));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
      cnt_q <= 32'h0;
      idx_q <= 2'd0;
      req_q <= 1'b0;
    end else if (stop) begin
      st_q <= S_IDLE;
      req_q <= 1'b0;
    end else if (start) begin
      st_q <= ref_ok ? S_RESET : S_ERR;
      cnt_q <= 32'h0;
      req_q <= 1'b0;
    end else begin
      case (st_q)
        S_RESET: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == 32'(RESET_CYCLES - 1)) begin
            st_q <= S_SETTLE; // RULE2
            cnt_q <= 32'h0;
          end
        end
        S_SETTLE: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == 32'(SETTLE_CYCLES - 1)) begin
            st_q <= S_CFG; // RULE4
            idx_q <= 2'd0;
            req_q <= 1'b1;
          end
        end
        S_CFG: if (link.cfg_ack) begin
          req_q <= 1'b0;
          idx_q <= idx_q + 2'd1;
          if (idx_q == 2'(INIT_WRITES - 1)) begin
            st_q <= S_VIDEO; // RULE5
          end
        end else begin
          req_q <= 1'b1;
        end
        S_VIDEO: begin
          st_q <= S_SYNTH; // RULE12
          req_q <= 1'b1;
        end
        S_SYNTH: if (link.cfg_ack) begin
          st_q <= S_POLL; // RULE6
          cnt_q <= 32'h0;
          req_q <= 1'b0;
        end
        S_POLL: if (link.cfg_ack) begin
          req_q <= 1'b0;
          cnt_q <= cnt_q + 32'h1;
          if (link.cfg_rdata[LOCK_BIT]) begin
            st_q <= S_RESTART; // RULE6
          end else if (cnt_q == 32'(POLL_LIMIT)) begin
            st_q <= S_ERR;
          end
        end else begin
          req_q <= 1'b1;
        end
        S_RESTART: req_q <= !link.cfg_ack && !req_q;
        default: req_q <= 1'b0;
      endcase
      if (st_q == S_RESTART && link.cfg_ack) st_q <= S_RUN;
    end
  end

  always_comb begin
    case (st_q)
      S_SYNTH: {addr_q, wdata_q} = {CFG_SYNTH, 8'h01};
      S_POLL: {addr_q, wdata_q} = {CFG_CLKSRC, 8'h00};
      S_RESTART: {addr_q, wdata_q} = {CFG_RESTART, 8'h01};
      default: {addr_q, wdata_q} = init_entry(idx_q, cfg0_q);
    endcase
    wr_q = st_q != S_POLL;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      video_q <= 1'b0;
    end else begin
      en_q <= st_q != S_IDLE && st_q != S_RESET && st_q != S_ERR; // RULE2
      video_q <= st_q == S_VIDEO || st_q == S_SYNTH || st_q == S_POLL ||
                 st_q == S_RESTART || st_q == S_RUN; // RULE5
    end
  end

  assign link.en = en_q;
  assign link.lp11 = !video_q; // RULE3
  assign link.hs_clk_cont = video_q && !cfg0_q[SRC_BIT]; // RULE8
  assign link.vid_valid = video_q && src_valid;
  assign link.vid_rgb = video_q ? src_rgb : 24'h000000;
  assign link.vid_hs = video_q && src_hs;
  assign link.vid_vs = video_q && src_vs;
  assign link.vid_de = video_q && src_de;
  assign link.cfg_req = req_q && !link.cfg_ack;
  assign link.cfg_wr = wr_q;
  assign link.cfg_addr = addr_q;
  assign link.cfg_wdata = wdata_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
endmodule

// [rtl/lane_mapper.sv]
// Pixel to seven-bit lane word mapping
module lane_mapper (
  input wire logic [23:0] rgb,
  input wire logic hs,
  input wire logic vs,
  input wire logic de,
  input wire logic layout_sel,
  input wire logic wide_mode,
  output logic [3:0][6:0] lane,
  output logic fourth_en
);
  logic [5:0] r6, g6, b6;
  logic [1:0] r2, g2, b2;
  logic msb_on_fourth;

  always_comb begin
    // Layout 0: top two bits on the fourth lane; layout 1: bottom two
    msb_on_fourth = wide_mode && !layout_sel; // RULE14
    r6 = msb_on_fourth ? rgb[21:16] : rgb[23:18]; // RULE15
    g6 = msb_on_fourth ? rgb[13:8] : rgb[15:10];
    b6 = msb_on_fourth ? rgb[5:0] : rgb[7:2];
    r2 = msb_on_fourth ? rgb[23:22] : rgb[17:16];
    g2 = msb_on_fourth ? rgb[15:14] : rgb[9:8];
    b2 = msb_on_fourth ? rgb[7:6] : rgb[1:0];
    fourth_en = wide_mode; // RULE16
    lane[0] = {g6[0], r6};
    lane[1] = {b6[1:0], g6[5:1]};
    lane[2] = {de, vs, hs, b6[5:2]};
    lane[3] = fourth_en ? {1'b0, b2, g2, r2} : 7'h00; // RULE16
  end
endmodule

// [shared/bridge_if.sv]
// Link between the display controller and the bridge device
interface bridge_if;
  logic en;
  logic lp11;
  logic hs_clk_cont;
  logic vid_valid;
  logic [23:0] vid_rgb;
  logic vid_hs;
  logic vid_vs;
  logic vid_de;
  logic cfg_req;
  logic cfg_wr;
  logic [7:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic cfg_ack;
  logic [7:0] cfg_rdata;
  modport dev (
    input en, lp11, hs_clk_cont, vid_valid, vid_rgb, vid_hs, vid_vs, vid_de,
    input cfg_req, cfg_wr, cfg_addr, cfg_wdata,
    output cfg_ack, cfg_rdata
  );
  modport host (
    output en, lp11, hs_clk_cont, vid_valid, vid_rgb, vid_hs, vid_vs, vid_de,
    output cfg_req, cfg_wr, cfg_addr, cfg_wdata,
    input cfg_ack, cfg_rdata
  );
endinterface

// [shared/bridge_pkg.sv]
// Constants shared by the bridge device end and its controller end
package bridge_pkg;
  localparam int CLK_MHZ = 250;
  localparam int RESET_MS = 10;
  localparam int RESET_CYC = RESET_MS * CLK_MHZ * 1000;
  localparam int SETTLE_MS = 1;
  localparam int SETTLE_CYC = SETTLE_MS * CLK_MHZ * 1000;
  localparam int LOCK_CYC = 64;
  localparam int POLL_LIMIT = 255;
  localparam int REF_MIN_MHZ = 25;
  localparam int REF_MAX_MHZ = 154;
  localparam int LANES = 4;
  // Device configuration register addresses
  localparam logic [7:0] CFG_RESTART = 8'h09;
  localparam logic [7:0] CFG_CLKSRC = 8'h0a;
  localparam logic [7:0] CFG_CLKDIV = 8'h0b;
  localparam logic [7:0] CFG_SYNTH = 8'h0d;
  localparam logic [7:0] CFG_BAND = 8'h12;
  localparam logic [7:0] CFG_FORMAT = 8'h18;
  // Field positions
  localparam int SRC_BIT = 0;
  localparam int LOCK_BIT = 7;
  localparam int RANGE_LO = 1;
  localparam int MULT_LO = 0;
  localparam int DIV_LO = 3;
  localparam int SYNTH_BIT = 0;
  localparam int RESTART_BIT = 0;
  localparam int LAYOUT_BIT = 1;
  localparam int WIDE_BIT = 3;
  localparam logic [7:0] CFG_RST = 8'h00;
  // Reference period in pclk cycles for each multiplier code
  localparam logic [7:0] REF_PER_X1 = 8'h0c;
  localparam logic [7:0] REF_PER_X2 = 8'h06;
  localparam logic [7:0] REF_PER_X3 = 8'h04;
  localparam logic [7:0] REF_PER_X4 = 8'h03;
  localparam logic [6:0] CLK_PATTERN = 7'h63;
  // Controller APB map
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CFG0 = 8'h04;
  localparam logic [7:0] A_CFG1 = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0c;
  localparam logic [7:0] A_INT_STAT = 8'h10;
  localparam logic [7:0] A_INT_MASK = 8'h14;
  localparam int INT_DONE = 0;
  localparam int INT_ERR = 1;
  localparam int INIT_WRITES = 4;
endpackage

// [verif/bridge_props.sv]
// Concurrent checks on the link between controller and bridge device
module bridge_props #(
  parameter int RESET_CYCLES = 20,
  parameter int SETTLE_CYCLES = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic lp11,
  input wire logic vid_valid,
  input wire logic cfg_req,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_ack,
  input wire logic [7:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import bridge_pkg::*;
  int low_q;
  int high_q;
  int wr_q;
  logic locked_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles spent with enable low and high, writes and lock seen since enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_q <= 0;
    else if (en) low_q <= 0;
    else if (low_q < RESET_CYCLES) low_q <= low_q + 1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) high_q <= 0;
    else if (!en) high_q <= 0;
    else if (high_q < SETTLE_CYCLES) high_q <= high_q + 1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_q <= 0;
    else if (!en) wr_q <= 0;
    else if (cfg_ack && cfg_wr && wr_q < 15) wr_q <= wr_q + 1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) locked_q <= 1'b0;
    else if (!en) locked_q <= 1'b0;
    else if (cfg_ack && !cfg_wr && cfg_addr == CFG_CLKSRC && cfg_rdata[LOCK_BIT]) locked_q <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  reset_hold_a: assert property ($rose(en) |-> low_q >= RESET_CYCLES - 1)
    else $error("enable raised before the reset hold time");
  lp11_reset_a: assert property (!en |-> lp11)
    else $error("lanes left LP11 while enable low");
  video_gate_a: assert property (lp11 |-> !vid_valid)
    else $error("video valid while lanes idle");
  settle_wait_a: assert property ($rose(cfg_req) |-> en && high_q >= SETTLE_CYCLES - 1)
    else $error("configuration started before settle time");
  cfg_answer_a: assert property (en && cfg_req && !cfg_ack |=>
    cfg_ack && !cfg_req && $stable(cfg_addr) && $stable(cfg_wr))
    else $error("configuration request not answered next cycle");
  ack_pulse_a: assert property (cfg_ack |=> !cfg_ack)
    else $error("configuration ack longer than one cycle");
  off_silent_a: assert property (!en && $past(en) == 1'b0 |-> !cfg_ack)
    else $error("device answered while disabled");
  video_order_a: assert property ($fell(lp11) |-> wr_q >= INIT_WRITES)
    else $error("video started before configuration loaded");
  synth_order_a: assert property (cfg_req && cfg_wr && cfg_addr == CFG_SYNTH |->
    !lp11 && wr_q >= INIT_WRITES)
    else $error("synthesizer enabled out of order");
  restart_lock_a: assert property (cfg_req && cfg_wr && cfg_addr == CFG_RESTART |-> locked_q)
    else $error("restart written before lock seen");
  cover property ($rose(en));
  cover property ($fell(lp11));
  cover property (cfg_req && cfg_wr && cfg_addr == CFG_RESTART);
endmodule

// [verif/dsi_lvds_bridge_setup_format_tb.sv]
// Self-checking bench for the controller and bridge device pair
module dsi_lvds_bridge_setup_format_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bridge_pkg::*;
  localparam int RST_N = 20;
  localparam int SET_N = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ref_clk_on;
  logic src_valid, src_hs, src_vs, src_de, clk_oe, synth_locked;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] src_rgb;
  logic [LANES-1:0][6:0] lane_bits;
  logic [LANES-1:0] lane_oe;
  logic [6:0] clk_bits;
  int n_fail, n_compared;
  bridge_if link ();
  bridge_host #(.RESET_CYCLES(RST_N), .SETTLE_CYCLES(SET_N)) u_bridge_host (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .src_valid(src_valid), .src_rgb(src_rgb), .src_hs(src_hs), .src_vs(src_vs),
    .src_de(src_de), .link(link));
  bridge_device u_bridge_device (.pclk(pclk), .presetn(presetn), .link(link),
    .ref_clk_on(ref_clk_on), .lane_bits(lane_bits), .lane_oe(lane_oe), .clk_bits(clk_bits),
    .clk_oe(clk_oe), .synth_locked(synth_locked));
  bridge_props #(.RESET_CYCLES(RST_N), .SETTLE_CYCLES(SET_N)) u_bridge_props (.pclk(pclk),
    .presetn(presetn), .en(link.en), .lp11(link.lp11), .vid_valid(link.vid_valid),
    .cfg_req(link.cfg_req), .cfg_wr(link.cfg_wr), .cfg_addr(link.cfg_addr),
    .cfg_ack(link.cfg_ack), .cfg_rdata(link.cfg_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic end_of_test;
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; pready, read data and error taken at the access edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic err, output logic [31:0] q);
    int i;
    logic e;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      n_fail++;
      end_of_test();
    end
    check("pslverr", err, e);
  endtask
  // Hold one pixel, or idle video, long enough for the slowest pixel period
  task automatic pixel(input logic on, input logic [6:0] y3, input logic [20:0] y012);
    @(posedge pclk);
    src_valid <= on;
    src_de <= on;
    src_vs <= 1'b1;
    src_hs <= 1'b0;
    src_rgb <= 24'hc53a96;
    repeat (40) @(posedge pclk);
    @(negedge pclk);
    check("lane3", on ? y3 : 7'h00, lane_bits[3]);
    if (!on) begin
      check("lane0 idle", 7'h00, lane_bits[0]);
      check("lane1 idle", 7'h00, lane_bits[1]);
      check("lane2 idle", 7'h20, lane_bits[2]);
    end else begin
      check("lane0", y012[6:0], lane_bits[0]);
      check("lane1", y012[13:7], lane_bits[1]);
      check("lane2", y012[20:14], lane_bits[2]);
    end
  endtask
  // Full bring-up with one configuration, then lane and interrupt checks
  task automatic run(input logic [31:0] cfg0, input logic [7:0] mhz, input logic ref_on,
                     input logic [1:0] mask, input logic [4:0] st, input logic [6:0] y3);
    int i;
    logic [1:0] ev;
    logic [20:0] y012;
    ev = st[4] ? 2'b01 : 2'b10;
    y012 = (cfg0[24 + WIDE_BIT] && !cfg0[24 + LAYOUT_BIT]) ? {7'h65, 7'h5d, 7'h05} :
           {7'h69, 7'h27, 7'h31};
    ref_clk_on <= ref_on;
    apb(1'b1, A_CTRL, 32'h2, 1'b0, rd);
    apb(1'b1, A_INT_MASK, {30'h0, mask}, 1'b0, rd);
    apb(1'b1, A_CFG0, cfg0, 1'b0, rd);
    apb(1'b1, A_CFG1, {24'h0, mhz}, 1'b0, rd);
    apb(1'b1, A_CTRL, 32'h1, 1'b0, rd);
    if (mhz >= REF_MIN_MHZ) begin
      for (i = 0; i < 64 && link.en !== 1'b0; i++) @(negedge pclk);
      repeat (2) @(negedge pclk);
      check("oe in reset", 5'h00, {clk_oe, lane_oe});
    end
    for (i = 0; i < 4000; i++) begin
      apb(1'b0, A_STATUS, 32'h0, 1'b0, rd);
      if (rd[3:0] >= 4'h8) break;
    end
    if (i == 4000) begin
      n_fail++;
      end_of_test();
    end
    check("status", st, rd[4:0]);
    @(negedge pclk);
    check("irq", |(ev & mask), irq);
    apb(1'b0, A_INT_STAT, 32'h0, 1'b0, rd);
    check("int_stat", ev, rd[1:0]);
    apb(1'b0, A_INT_STAT, 32'h0, 1'b0, rd);
    check("int_stat clr", 2'b00, rd[1:0]);
    @(negedge pclk);
    check("irq clr", 1'b0, irq);
    check("lane_oe", st[4] ? {cfg0[24 + WIDE_BIT], 3'b111} : 4'h0, lane_oe);
    check("clk_oe", st[4], clk_oe);
    check("synth_locked", st[4], synth_locked);
    if (st[4]) begin
      check("clk_bits", CLK_PATTERN, clk_bits);
      pixel(1'b0, y3, y012);
      pixel(1'b1, y3, y012);
      @(posedge pclk);
      src_valid <= 1'b0;
      src_de <= 1'b0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ref_clk_on = 1'b0;
    src_valid = 1'b0;
    src_rgb = 24'h0;
    src_hs = 1'b0;
    src_vs = 1'b0;
    src_de = 1'b0;
    n_fail = 0;
    n_compared = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_STATUS, 32'h0, 1'b0, rd);
    check("status rst", 32'h0, rd);
    apb(1'b0, A_INT_MASK, 32'h0, 1'b0, rd);
    check("mask rst", 32'h0, rd);
    apb(1'b1, 8'h20, 32'hffff_ffff, 1'b1, rd);
    apb(1'b0, 8'h20, 32'h0, 1'b1, rd);
    check("unmapped", 32'h0, rd);
    check("oe idle", 5'h00, {clk_oe, lane_oe});
    run({8'h08, 8'h30, 8'h08, 8'h04}, 8'd100, 1'b0, 2'b11, 5'h18, 7'h23);
    run({8'h0a, 8'h30, 8'h08, 8'h04}, 8'd100, 1'b0, 2'b01, 5'h18, 7'h29);
    run({8'h02, 8'h30, 8'h01, 8'h05}, 8'd100, 1'b1, 2'b01, 5'h18, 7'h00);
    run({8'h08, 8'h30, 8'h03, 8'h05}, 8'd154, 1'b1, 2'b11, 5'h18, 7'h23);
    run({8'h08, 8'h30, 8'h03, 8'h05}, 8'd100, 1'b0, 2'b10, 5'h09, 7'h00);
    run({8'h08, 8'h30, 8'h00, 8'h05}, 8'd20, 1'b1, 2'b00, 5'h09, 7'h00);
    end_of_test();
  end
endmodule
